// *** rmp_pkg.sv ***
// Package with constants and carriers for the reset mode pin latch.
package rmp_pkg;
	localparam int RMP_DATA_W = 12;
	localparam int RMP_BOOT_BIT = 0;
	localparam int RMP_ARB_BIT = 1;
	localparam int RMP_FC_BIT = 2;
	localparam int RMP_ADDR_LO_BIT = 3;
	localparam int RMP_ADDR_N = 5;
	localparam int RMP_DISCRETE_PORT_A_BIT = 8;
	localparam int RMP_DISCRETE_PORT_B_BIT = 9;
	localparam int RMP_TEST_BIT = 11;
	localparam logic [RMP_DATA_W-1:0] RMP_PINS_RST = 12'hfff;
	localparam logic [1:0] RMP_AUX_RST = 2'h3;
	// Enabled edges after reset release that refill the synchronisers.
	localparam logic [1:0] RMP_SETTLE_N = 2'h2;

	typedef struct packed {
		logic boot_16bit;
		logic cs_not_arb;
		logic cs_not_fc;
		logic [RMP_ADDR_N-1:0] addr_lines;
		logic bus_ctl_not_port_a;
		logic irq_not_port_b;
		logic test_mode;
		logic clk_from_synth;
		logic bdm_enable;
	} rmp_cfg_t;

	typedef struct packed {
		logic [RMP_DATA_W-1:0] data_s1;
		logic [RMP_DATA_W-1:0] data_s2;
		logic [1:0] aux_s1;
		logic [1:0] aux_s2;
		logic [1:0] settle;
		logic latched;
		rmp_cfg_t cfg;
	} rmp_state_t;

	localparam rmp_cfg_t RMP_CFG_RST = '{boot_16bit: 1'b1, cs_not_arb: 1'b1,
		cs_not_fc: 1'b1, addr_lines: 5'h00, bus_ctl_not_port_a: 1'b1,
		irq_not_port_b: 1'b1, test_mode: 1'b0, clk_from_synth: 1'b1,
		bdm_enable: 1'b0};
endpackage

// *** rmp_pulldown_model.sv ***
// Board straps that hold the mode pins low while the device is in reset.
`timescale 1ns/1ps
`default_nettype none
module rmp_pulldown_model
	import rmp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [13:0] pull_lo_i,
	output logic [RMP_DATA_W-1:0] data_pins_o,
	output logic clock_source_select_o,
	output logic breakpoint_pin_o
);
	logic [3:0] hold;
	logic [13:0] wander = 14'h1555;
	// Straps stay on a few cycles past release to cover the synchronisers.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold <= 4'h8;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
	end
	// Afterwards the bus carries other traffic, so the pins keep moving.
	always_ff @(posedge sys_clk_i) begin
		wander <= ~wander;
	end
	assign {breakpoint_pin_o, clock_source_select_o, data_pins_o} =
		(!rst_n_i || hold != 4'h0) ? ~pull_lo_i : wander;
endmodule
`default_nettype wire

// *** rmp_reset_mode_pins.sv ***
// Reset-time mode pin sampler and latched pin-function selections.
`timescale 1ns/1ps
`default_nettype none
module rmp_reset_mode_pins
	import rmp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [RMP_DATA_W-1:0] data_pins_i,
	input wire logic clock_source_select_i,
	input wire logic breakpoint_pin_i,
	output logic boot_16bit_o,
	output logic cs_not_arb_o,
	output logic cs_not_fc_o,
	output logic [RMP_ADDR_N-1:0] addr_lines_o,
	output logic bus_ctl_not_port_a_o,
	output logic irq_not_port_b_o,
	output logic test_mode_o,
	output logic clk_from_synth_o,
	output logic bdm_enable_o,
	output logic modes_valid_o
);
	rmp_state_t st;
	rmp_state_t next_st;

	// Each low address strap converts one more chip select, so the result
	// is a thermometer code: bit k is set when any strap from k upward is
	// low. A high strap below a low one cannot punch a hole in the code.
	function automatic logic [RMP_ADDR_N-1:0] addr_decode(
		input logic [RMP_ADDR_N-1:0] lines
	);
		logic [RMP_ADDR_N-1:0] low;
		low = ~lines;
		addr_decode = '0;
		for (int k = 0; k < RMP_ADDR_N; k++) begin
			addr_decode[k] = |(low >> k);
		end
	endfunction

	// The synchronisers are preset to all ones by the asynchronous reset, so their
	// output means nothing until enabled edges have refilled them. The
	// decode therefore waits RMP_SETTLE_N enabled edges after release and
	// then takes levels that passed both flip-flops. Board straps must
	// stay in place that long; the price is a short delay before the
	// selections become valid, and the reset branch loads constants only.
	always_comb begin
		next_st = st;
		next_st.data_s1 = data_pins_i;
		next_st.data_s2 = st.data_s1;
		next_st.aux_s1 = {clock_source_select_i, breakpoint_pin_i};
		next_st.aux_s2 = st.aux_s1;
		if (!st.latched && st.settle != RMP_SETTLE_N) begin
			next_st.settle = st.settle + 2'h1;
		end else if (!st.latched) begin
			next_st.latched = 1'b1;
			next_st.cfg.boot_16bit = st.data_s2[RMP_BOOT_BIT];
			next_st.cfg.cs_not_arb = st.data_s2[RMP_ARB_BIT];
			next_st.cfg.cs_not_fc = st.data_s2[RMP_FC_BIT];
			next_st.cfg.addr_lines =
				addr_decode(st.data_s2[RMP_ADDR_LO_BIT +: RMP_ADDR_N]);
			next_st.cfg.bus_ctl_not_port_a = st.data_s2[RMP_DISCRETE_PORT_A_BIT];
			next_st.cfg.irq_not_port_b = st.data_s2[RMP_DISCRETE_PORT_B_BIT];
			next_st.cfg.test_mode = ~st.data_s2[RMP_TEST_BIT];
			next_st.cfg.clk_from_synth = st.aux_s2[1];
			next_st.cfg.bdm_enable = ~st.aux_s2[0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st.data_s1 <= RMP_PINS_RST;
			st.data_s2 <= RMP_PINS_RST;
			st.aux_s1 <= RMP_AUX_RST;
			st.aux_s2 <= RMP_AUX_RST;
			st.settle <= 2'h0;
			st.latched <= 1'b0;
			st.cfg <= RMP_CFG_RST;
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	assign boot_16bit_o = st.cfg.boot_16bit;
	assign cs_not_arb_o = st.cfg.cs_not_arb;
	assign cs_not_fc_o = st.cfg.cs_not_fc;
	assign addr_lines_o = st.cfg.addr_lines;
	assign bus_ctl_not_port_a_o = st.cfg.bus_ctl_not_port_a;
	assign irq_not_port_b_o = st.cfg.irq_not_port_b;
	assign test_mode_o = st.cfg.test_mode;
	assign clk_from_synth_o = st.cfg.clk_from_synth;
	assign bdm_enable_o = st.cfg.bdm_enable;
	assign modes_valid_o = st.latched;

	// The checks below sample on the system clock and are off while the
	// reset input is low, when every flip-flop holds its constant.
	sequence s_settle;
		!st.latched && st.settle != RMP_SETTLE_N && clk_en_i;
	endsequence
	sequence s_latch;
		!st.latched && st.settle == RMP_SETTLE_N && clk_en_i;
	endsequence

	property p_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(st.latched) |-> $stable(st.cfg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("mode changed after latch");

	property p_once;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		st.latched |=> st.latched;
	endproperty
	a_once: assert property (p_once)
		else $error("latch dropped before reset");

	property p_defaults;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!st.latched |-> st.cfg == RMP_CFG_RST;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("selection shown before latch");

	// A low enable must not let the synchronisers creep forward, or a long
	// enable gap after release would sample pins that have moved on.
	property p_freeze;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!clk_en_i |=> $stable(st);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved with enable low");

	property p_sync;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		clk_en_i |=> st.data_s2 == $past(st.data_s1) &&
			st.aux_s2 == $past(st.aux_s1);
	endproperty
	a_sync: assert property (p_sync)
		else $error("pin synchroniser skipped a stage");

	property p_early;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_settle |=> !modes_valid_o;
	endproperty
	a_early: assert property (p_early)
		else $error("selections valid too early");

	property p_valid;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> modes_valid_o;
	endproperty
	a_valid: assert property (p_valid)
		else $error("selections not latched");

	property p_boot;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> boot_16bit_o == $past(st.data_s2[RMP_BOOT_BIT]);
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot width wrong");

	property p_arb;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> cs_not_arb_o == $past(st.data_s2[RMP_ARB_BIT]);
	endproperty
	a_arb: assert property (p_arb)
		else $error("arbitration select wrong");

	property p_fc;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> cs_not_fc_o == $past(st.data_s2[RMP_FC_BIT]);
	endproperty
	a_fc: assert property (p_fc)
		else $error("function code select wrong");

	property p_addr;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> addr_lines_o[0] ==
			$past(~&st.data_s2[RMP_ADDR_LO_BIT+RMP_ADDR_N-1:RMP_ADDR_LO_BIT]);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address line 19 wrong");

	property p_addr_top;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> addr_lines_o[RMP_ADDR_N-1] ==
			$past(~st.data_s2[RMP_ADDR_LO_BIT+RMP_ADDR_N-1]);
	endproperty
	a_addr_top: assert property (p_addr_top)
		else $error("address line 23 wrong");

	property p_addr_therm;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((addr_lines_o + 5'h01) & addr_lines_o) == 5'h00;
	endproperty
	a_addr_therm: assert property (p_addr_therm)
		else $error("address lines not cumulative");

	property p_pe;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> bus_ctl_not_port_a_o == $past(st.data_s2[RMP_DISCRETE_PORT_A_BIT]);
	endproperty
	a_pe: assert property (p_pe)
		else $error("port a select wrong");

	property p_pf;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> irq_not_port_b_o == $past(st.data_s2[RMP_DISCRETE_PORT_B_BIT]);
	endproperty
	a_pf: assert property (p_pf)
		else $error("port b select wrong");

	property p_test;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> test_mode_o != $past(st.data_s2[RMP_TEST_BIT]);
	endproperty
	a_test: assert property (p_test)
		else $error("test mode wrong");

	property p_clk;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> clk_from_synth_o == $past(st.aux_s2[1]);
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock source wrong");

	property p_bdm;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_latch |=> bdm_enable_o != $past(st.aux_s2[0]);
	endproperty
	a_bdm: assert property (p_bdm)
		else $error("debug enable wrong");
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the reset mode pin latch.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rmp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [13:0] pull_lo = 14'h0000;
	logic [RMP_DATA_W-1:0] pins;
	logic csel, breakpoint_pin;
	wire logic valid;
	wire rmp_cfg_t s;
	rmp_cfg_t e;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	always #5 sys_clk = ~sys_clk;
	rmp_pulldown_model rmp_pulldown_model_i (.sys_clk_i(sys_clk),
		.rst_n_i(rst_n), .pull_lo_i(pull_lo), .data_pins_o(pins),
		.clock_source_select_o(csel), .breakpoint_pin_o(breakpoint_pin));
	rmp_reset_mode_pins rmp_reset_mode_pins_i (.sys_clk_i(sys_clk),
		.rst_n_i(rst_n), .clk_en_i(clk_en), .data_pins_i(pins),
		.clock_source_select_i(csel), .breakpoint_pin_i(breakpoint_pin),
		.boot_16bit_o(s.boot_16bit), .cs_not_arb_o(s.cs_not_arb),
		.cs_not_fc_o(s.cs_not_fc), .addr_lines_o(s.addr_lines),
		.bus_ctl_not_port_a_o(s.bus_ctl_not_port_a),
		.irq_not_port_b_o(s.irq_not_port_b), .test_mode_o(s.test_mode),
		.clk_from_synth_o(s.clk_from_synth), .bdm_enable_o(s.bdm_enable),
		.modes_valid_o(valid));
	task check(input string what, input logic [7:0] seen, input logic [7:0] ex);
		check_count++;
		if (seen !== ex) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, ex, seen);
		end
	endtask
	task cmp_all(input logic v);
		check("valid", {7'h00, valid}, {7'h00, v});
		check("boot", {7'h00, s.boot_16bit}, {7'h00, e.boot_16bit});
		check("arb", {7'h00, s.cs_not_arb}, {7'h00, e.cs_not_arb});
		check("fc", {7'h00, s.cs_not_fc}, {7'h00, e.cs_not_fc});
		check("addr", {3'h0, s.addr_lines}, {3'h0, e.addr_lines});
		check("pa", {7'h00, s.bus_ctl_not_port_a}, {7'h00, e.bus_ctl_not_port_a});
		check("pb", {7'h00, s.irq_not_port_b}, {7'h00, e.irq_not_port_b});
		check("test", {7'h00, s.test_mode}, {7'h00, e.test_mode});
		check("clk", {7'h00, s.clk_from_synth}, {7'h00, e.clk_from_synth});
		check("bdm", {7'h00, s.bdm_enable}, {7'h00, e.bdm_enable});
	endtask
	task run_case(input logic [13:0] m, input int gap);
		@(posedge sys_clk);
		pull_lo <= m;
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		e = RMP_CFG_RST;
		cmp_all(1'b0);
		rst_n <= 1'b1;
		// Enable gap must stay short of the straps' hold after release.
		if (gap != 0) begin
			clk_en <= 1'b0;
			repeat (gap) @(posedge sys_clk);
			cmp_all(1'b0);
			clk_en <= 1'b1;
		end
		e = '{~m[0], ~m[1], ~m[2], 5'h00, ~m[8], ~m[9], m[11], ~m[12], m[13]};
		for (int j = 0; j < 5; j++) if (m[3+j]) e.addr_lines = 5'h1f >> (4 - j);
		repeat (5) @(posedge sys_clk);
		cmp_all(1'b1);
		repeat (12) @(posedge sys_clk);
		cmp_all(1'b1);
		$display("Test with straps %h done", m);
	endtask
	task conclude();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		run_case(14'h0000, 0);
		for (int i = 0; i < 14; i++) if (i != 10) run_case(14'h0001 << i, 0);
		run_case(14'h00a8, 4);
		run_case(14'h3fff, 0);
		conclude();
	end
endmodule
`default_nettype wire
